// ==== src/iosm_top.sv ====
// terminal status words and maintenance counters for the keypad display
//
// Function
// - status words are 16 bits, unassigned bits zero
// - each word shown as four hex digits
// - forward input bit 0, reverse bit 1
// - general inputs one to three at bits 2-4
// - input bit is 1 when shorted to common
// - output bit 0 follows transistor output conduction
// - output bit 8 follows relay no-contact closure
// - input bits 13-15 reserved for link commands
// - link control adds link inputs, clears outputs
// - power-on hours shown in thousands, two scales
// - power-on hours wrap to zero past 65535
// - capacitor and fan hours saturate at 65535
// - fan hours pause while fan stopped, control on
// - startups count run command rising edges
// - link error count returns to zero past 9999
// - hold latest link error code in hex
// - track hourly maximum heat sink and current
// - show firmware version; keypad version if remote
// - source wiring judges inputs against source common
`default_nettype none
module iosm_top #(
    parameter longint HOUR_CYCLES = iosm_pkg::HOUR_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    input wire logic [2:0] general_inputs,
    input wire logic source_select,
    input wire logic transistor_output,
    input wire logic relay_no_contact,
    input wire logic link_control,
    input wire logic link_forward_cmd,
    input wire logic link_reverse_cmd,
    input wire logic link_reset_cmd,
    input wire logic run_cmd,
    input wire logic fan_running,
    input wire logic fan_onoff_control_setting,
    input wire logic link_error,
    input wire logic [7:0] link_error_code,
    input wire logic [7:0] heat_sink_temp,
    input wire logic [15:0] output_current,
    input wire logic remote_keypad,
    input wire logic [15:0] keypad_version,
    input wire logic [15:0] nv_power_hours,
    input wire logic [15:0] nv_cap_hours,
    input wire logic [15:0] nv_fan_hours,
    input wire logic [15:0] nv_startups,
    input wire logic nv_load,
    output logic [15:0] input_status,
    output logic [15:0] output_status,
    output logic [15:0] input_hex,
    output logic [15:0] output_hex,
    output logic [15:0] power_hours,
    output logic [15:0] cap_hours,
    output logic [15:0] fan_hours,
    output logic [15:0] startups,
    output logic [15:0] power_disp,
    output logic [15:0] cap_disp,
    output logic [15:0] fan_disp,
    output logic [15:0] startup_disp,
    output logic [15:0] disp_coarse,
    output logic [15:0] error_count,
    output logic [7:0] last_error_code,
    output logic [7:0] max_heat_sink,
    output logic [15:0] max_current,
    output logic [15:0] fw_version,
    output logic [15:0] keypad_version_disp,
    output logic keypad_version_valid,
    output logic hour_tick
);
    // two-flop synchronisers for every pin input (terminal inputs are active-low to common with sink wiring, active-high with source wiring)
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] pin_s;
    // no pad bit: every synchroniser stage carries a live pin
    assign pin_raw = {link_error, fan_running, run_cmd, relay_no_contact, transistor_output,
                      source_select, general_inputs, reverse_run_input, forward_run_input};

    // first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync_a <= '0;
            pin_s <= '0;
        end else begin
            sync_a <= pin_raw;
            pin_s <= sync_a;
        end
    end

    logic fwd_s, rev_s, src_s, tr_s, relay_s, run_s, fan_s, err_s;
    logic [2:0] gen_s;
    assign fwd_s = pin_s[0];
    assign rev_s = pin_s[1];
    assign gen_s = pin_s[4:2];
    assign src_s = pin_s[5];
    assign tr_s = pin_s[6];
    assign relay_s = pin_s[7];
    assign run_s = pin_s[8];
    assign fan_s = pin_s[9];
    assign err_s = pin_s[10];

    // terminal level is 1 when shorted to the chosen common; the inputs report
    // low-true closure for sink wiring and high-true for source wiring
    logic [4:0] term_on;
    assign term_on = src_s ? {gen_s, rev_s, fwd_s} : ~{gen_s, rev_s, fwd_s};

    // status words; unlisted bits stay zero
    logic [15:0] next_in_word;
    logic [15:0] next_out_word;
    always_comb begin
        next_in_word = iosm_pkg::RESET_WORD;
        next_out_word = iosm_pkg::RESET_WORD;
        next_in_word[iosm_pkg::IN_FWD_BIT] = term_on[0];
        next_in_word[iosm_pkg::IN_REV_BIT] = term_on[1];
        for (int i = 0; i < iosm_pkg::NUM_GEN_INPUTS; i++) begin
            next_in_word[iosm_pkg::IN_GEN_BIT0 + i] = term_on[2 + i];
        end
        if (link_control) begin
            // link words are logic-side, no sync needed
            next_in_word[iosm_pkg::IN_LINK_FWD_BIT] = link_forward_cmd;
            next_in_word[iosm_pkg::IN_LINK_REV_BIT] = link_reverse_cmd;
            next_in_word[iosm_pkg::IN_LINK_RST_BIT] = link_reset_cmd;
        end else begin
            next_out_word[iosm_pkg::OUT_TR_BIT] = tr_s;
            next_out_word[iosm_pkg::OUT_RELAY_BIT] = relay_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            input_status <= iosm_pkg::RESET_WORD;
            output_status <= iosm_pkg::RESET_WORD;
        end else begin
            input_status <= next_in_word;
            output_status <= next_out_word;
        end
    end

    // hex digit per nibble: value 0..F, one digit code per nibble
    genvar g;
    generate
        for (g = 0; g < iosm_pkg::NIBBLES; g++) begin : g_hex
            assign input_hex[4*g +: 4] = input_status[4*g +: 4];
            assign output_hex[4*g +: 4] = output_status[4*g +: 4];
        end
    endgenerate

    // one-hour tick divider; a long count, shortened in simulation by parameter
    logic [39:0] hour_cnt;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hour_cnt <= '0;
            hour_tick <= 1'b0;
        end else if (hour_cnt == 40'(HOUR_CYCLES - 1)) begin
            hour_cnt <= '0;
            hour_tick <= 1'b1;
        end else begin
            hour_cnt <= hour_cnt + 40'h1;
            hour_tick <= 1'b0;
        end
    end

    // hour counters, restored from nonvolatile store on load
    logic fan_counts;
    assign fan_counts = fan_s || !fan_onoff_control_setting;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            power_hours <= iosm_pkg::RESET_WORD;
            cap_hours <= iosm_pkg::RESET_WORD;
            fan_hours <= iosm_pkg::RESET_WORD;
        end else if (nv_load) begin
            power_hours <= nv_power_hours;
            cap_hours <= nv_cap_hours;
            fan_hours <= nv_fan_hours;
        end else if (hour_tick) begin
            power_hours <= power_hours + 16'h1;
            if (cap_hours != iosm_pkg::COUNT_MAX) begin
                cap_hours <= cap_hours + 16'h1;
            end
            if (fan_counts && fan_hours != iosm_pkg::COUNT_MAX) begin
                fan_hours <= fan_hours + 16'h1;
            end
        end
    end

    // startup counter on run command rising edge, saturating
    logic run_d;
    logic run_rise;
    assign run_rise = run_s && !run_d;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_d <= 1'b0;
            startups <= iosm_pkg::RESET_WORD;
        end else begin
            run_d <= run_s;
            if (nv_load) begin
                startups <= nv_startups;
            end else if (run_rise && startups != iosm_pkg::COUNT_MAX) begin
                startups <= startups + 16'h1;
            end
        end
    end

    // display scaling: below 10,000 shows raw count in thousandths, above in tens
    function automatic logic [15:0] iosm_scale(input logic [15:0] v);
        iosm_scale = (v < iosm_pkg::FINE_LIMIT) ? v : v / iosm_pkg::COARSE_DIV;
    endfunction : iosm_scale

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            power_disp <= iosm_pkg::RESET_WORD;
            cap_disp <= iosm_pkg::RESET_WORD;
            fan_disp <= iosm_pkg::RESET_WORD;
            startup_disp <= iosm_pkg::RESET_WORD;
            disp_coarse <= iosm_pkg::RESET_WORD;
        end else begin
            power_disp <= iosm_scale(power_hours);
            cap_disp <= iosm_scale(cap_hours);
            fan_disp <= iosm_scale(fan_hours);
            startup_disp <= iosm_scale(startups);
            // per-counter flag: decimal point after two digits instead of one
            disp_coarse <= {12'h000,
                            startups >= iosm_pkg::FINE_LIMIT,
                            fan_hours >= iosm_pkg::FINE_LIMIT,
                            cap_hours >= iosm_pkg::FINE_LIMIT,
                            power_hours >= iosm_pkg::FINE_LIMIT};
        end
    end

    // link error count and last code; not kept over power loss
    logic err_d;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            err_d <= 1'b0;
            error_count <= iosm_pkg::RESET_WORD;
            last_error_code <= iosm_pkg::RESET_BYTE;
        end else begin
            err_d <= err_s;
            if (err_s && !err_d) begin
                last_error_code <= link_error_code;
                if (error_count == iosm_pkg::ERR_LIMIT) begin
                    error_count <= iosm_pkg::RESET_WORD;
                end else begin
                    error_count <= error_count + 16'h1;
                end
            end
        end
    end

    // hourly maxima: running peaks restart each hour, published on the tick
    logic [7:0] peak_temp;
    logic [15:0] peak_cur;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            peak_temp <= iosm_pkg::RESET_BYTE;
            peak_cur <= iosm_pkg::RESET_WORD;
            max_heat_sink <= iosm_pkg::RESET_BYTE;
            max_current <= iosm_pkg::RESET_WORD;
        end else if (hour_tick) begin
            max_heat_sink <= peak_temp;
            max_current <= peak_cur;
            peak_temp <= heat_sink_temp;
            peak_cur <= output_current;
        end else begin
            if (heat_sink_temp > peak_temp) begin
                peak_temp <= heat_sink_temp;
            end
            if (output_current > peak_cur) begin
                peak_cur <= output_current;
            end
        end
    end

    // versions; keypad version only with a remote keypad
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fw_version <= iosm_pkg::RESET_WORD;
            keypad_version_disp <= iosm_pkg::RESET_WORD;
            keypad_version_valid <= 1'b0;
        end else begin
            fw_version <= iosm_pkg::FW_VERSION;
            keypad_version_valid <= remote_keypad;
            keypad_version_disp <= remote_keypad ? keypad_version : iosm_pkg::RESET_WORD;
        end
    end

    // checks
    property p_link_clears_out;
        @(posedge ref_clk) disable iff (reset)
        link_control |=> output_status == 16'h0000;
    endproperty
    a_link_clears_out: assert property (p_link_clears_out)
        else $error("output word not clear under link control");

    property p_unused_zero;
        @(posedge ref_clk) disable iff (reset)
        input_status[12:5] == 8'h00 && output_status[15:9] == 7'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unassigned status bit set");

    property p_reserved_off;
        @(posedge ref_clk) disable iff (reset)
        !link_control |=> input_status[15:13] == 3'b000;
    endproperty
    a_reserved_off: assert property (p_reserved_off)
        else $error("reserved bits set without link control");

    property p_power_wrap;
        @(posedge ref_clk) disable iff (reset)
        hour_tick && !nv_load && power_hours == 16'hFFFF |=> power_hours == 16'h0000;
    endproperty
    a_power_wrap: assert property (p_power_wrap)
        else $error("power hours did not wrap");

    property p_cap_hold;
        @(posedge ref_clk) disable iff (reset)
        !nv_load && cap_hours == iosm_pkg::COUNT_MAX |=> cap_hours == iosm_pkg::COUNT_MAX;
    endproperty
    a_cap_hold: assert property (p_cap_hold)
        else $error("capacitor hours left saturation");

    property p_fan_pause;
        @(posedge ref_clk) disable iff (reset)
        !nv_load && fan_onoff_control_setting && !fan_s |=> $stable(fan_hours);
    endproperty
    a_fan_pause: assert property (p_fan_pause)
        else $error("fan hours advanced while fan stopped");

    property p_startup_inc;
        @(posedge ref_clk) disable iff (reset)
        run_rise && !nv_load && startups < 16'hFFFF |=> startups == $past(startups) + 16'h1;
    endproperty
    a_startup_inc: assert property (p_startup_inc)
        else $error("startup count missed a run edge");

    property p_err_wrap;
        @(posedge ref_clk) disable iff (reset)
        error_count <= iosm_pkg::ERR_LIMIT;
    endproperty
    a_err_wrap: assert property (p_err_wrap)
        else $error("error count beyond limit");

    property p_power_disp;
        @(posedge ref_clk) disable iff (reset)
        power_hours == 16'hFFFF |=> power_disp == 16'h1999;
    endproperty
    a_power_disp: assert property (p_power_disp)
        else $error("coarse power hour display wrong");

    property p_tick_gap;
        @(posedge ref_clk) disable iff (reset)
        hour_tick |=> !hour_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("hour tick longer than one cycle");

    c_link_mode: cover property (@(posedge ref_clk) link_control && input_status[13]);
    c_hour: cover property (@(posedge ref_clk) hour_tick);
    c_startup: cover property (@(posedge ref_clk) run_rise);
    c_error: cover property (@(posedge ref_clk) err_s && !err_d);
endmodule : iosm_top
`default_nettype wire

// ==== src/iosm_pkg.sv ====
// package of constants for the i/o status and maintenance counter block
`default_nettype none
package iosm_pkg;
    // status word bit positions
    localparam int IN_FWD_BIT = 0;
    localparam int IN_REV_BIT = 1;
    localparam int IN_GEN_BIT0 = 2;
    localparam int IN_LINK_FWD_BIT = 13;
    localparam int IN_LINK_REV_BIT = 14;
    localparam int IN_LINK_RST_BIT = 15;
    localparam int OUT_TR_BIT = 0;
    localparam int OUT_RELAY_BIT = 8;
    localparam int NUM_GEN_INPUTS = 3;
    localparam int WORD_W = 16;
    localparam int NIBBLES = 4;
    // counter limits and display scaling
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] FINE_LIMIT = 16'h2710;    // 10,000
    localparam logic [15:0] ERR_LIMIT = 16'h270F;     // 9,999
    localparam logic [15:0] COARSE_DIV = 16'h000A;
    // timing: one-hour tick from the 100 MHz clock
    localparam longint CLK_HZ = 100000000;
    localparam longint HOUR_S = 3600;
    localparam longint HOUR_CYCLES = CLK_HZ * HOUR_S;
    // version value; arbitrary
    localparam logic [15:0] FW_VERSION = 16'h0100;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : iosm_pkg
`default_nettype wire

// ==== test/iosm_terminals.sv ====
// model of the control terminals wired to the block's input pins
`default_nettype none
module iosm_terminals (
    input wire logic source_select,
    input wire logic fwd_on,
    input wire logic rev_on,
    input wire logic [2:0] gen_on,
    output logic forward_run_input,
    output logic reverse_run_input,
    output logic [2:0] general_inputs
);
    timeunit 1ns;
    timeprecision 100ps;
    // sink wiring pulls a closed terminal low, source wiring drives it high
    always_comb begin
        forward_run_input = source_select ? fwd_on : ~fwd_on;
        reverse_run_input = source_select ? rev_on : ~rev_on;
        general_inputs = source_select ? gen_on : ~gen_on;
    end
endmodule : iosm_terminals
`default_nettype wire

// ==== test/io_status_and_maintenance_counters_test.sv ====
// self-checking bench for the terminal status and maintenance counter block
`default_nettype none
module io_status_and_maintenance_counters_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, reset = 1'b1, fwd_on = 1'b0, rev_on = 1'b0, source_select = 1'b0;
    logic [2:0] gen_on = 3'h0;
    logic transistor_output = 1'b0, relay_no_contact = 1'b0, link_control = 1'b0;
    logic link_forward_cmd = 1'b0, link_reverse_cmd = 1'b0, link_reset_cmd = 1'b0;
    logic run_cmd = 1'b0, fan_running = 1'b0, fan_onoff_control_setting = 1'b0;
    logic link_error = 1'b0, remote_keypad = 1'b0, nv_load = 1'b0;
    logic [7:0] link_error_code = 8'h00, heat_sink_temp = 8'h00, peak_heat;
    logic [15:0] output_current = 16'h0000, keypad_version = 16'h0000, peak_cur;
    logic [15:0] nv_power_hours = 16'h0000, nv_cap_hours = 16'h0000;
    logic [15:0] nv_fan_hours = 16'h0000, nv_startups = 16'h0000;
    logic forward_run_input, reverse_run_input, keypad_version_valid, hour_tick;
    logic [2:0] general_inputs;
    logic [15:0] input_status, output_status, input_hex, output_hex, power_hours, cap_hours;
    logic [15:0] fan_hours, startups, power_disp, cap_disp, fan_disp, startup_disp;
    logic [15:0] disp_coarse, error_count, max_current, fw_version, keypad_version_disp;
    logic [7:0] last_error_code, max_heat_sink;
    logic [7:0] code_now;
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'h69CA5348;
    int sel_q[$];
    logic [15:0] exp_q[$];

    iosm_terminals iosm_terminals_i (.source_select, .fwd_on, .rev_on, .gen_on,
        .forward_run_input, .reverse_run_input, .general_inputs);

    // short hour so the hour counters move within the run
    iosm_top #(.HOUR_CYCLES(10)) iosm_top_i (.ref_clk, .reset, .forward_run_input,
        .reverse_run_input, .general_inputs, .source_select, .transistor_output,
        .relay_no_contact, .link_control, .link_forward_cmd, .link_reverse_cmd,
        .link_reset_cmd, .run_cmd, .fan_running, .fan_onoff_control_setting, .link_error,
        .link_error_code, .heat_sink_temp, .output_current, .remote_keypad, .keypad_version,
        .nv_power_hours, .nv_cap_hours, .nv_fan_hours, .nv_startups, .nv_load,
        .input_status, .output_status, .input_hex, .output_hex, .power_hours, .cap_hours,
        .fan_hours, .startups, .power_disp, .cap_disp, .fan_disp, .startup_disp, .disp_coarse,
        .error_count, .last_error_code, .max_heat_sink, .max_current, .fw_version,
        .keypad_version_disp, .keypad_version_valid, .hour_tick);

    // free-running clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] pick(input int sel);
        case (sel)
            0: return input_status;
            1: return output_status;
            2: return input_hex;
            3: return output_hex;
            4: return power_hours;
            5: return cap_hours;
            6: return fan_hours;
            7: return startups;
            8: return power_disp;
            9: return cap_disp;
            10: return fan_disp;
            11: return startup_disp;
            12: return disp_coarse;
            13: return error_count;
            14: return max_current;
            15: return fw_version;
            16: return keypad_version_disp;
            17: return {8'h00, last_error_code};
            18: return {8'h00, max_heat_sink};
            default: return {15'h0000, keypad_version_valid};
        endcase
    endfunction : pick

    task automatic final_report;
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk_word(input int sel, input logic [15:0] exp);
        comparisons++;
        if (pick(sel) !== exp) begin
            err_count++;
            $display("BAD %0t output %0d got %h want %h", $time, sel, pick(sel), exp);
        end
    endtask : chk_word

    // watcher: settled outputs are compared against the oldest notes at mid-cycle
    always @(negedge ref_clk) begin
        while (exp_q.size() > 0) begin
            chk_word(sel_q.pop_front(), exp_q.pop_front());
        end
    end

    task automatic note(input int sel, input logic [15:0] exp);
        sel_q.push_back(sel);
        exp_q.push_back(exp);
    endtask : note

    // inputs always change one small delay after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wait_tick;
        int n;
        n = 0;
        while (hour_tick !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        if (n >= 40) begin
            err_count++;
            $display("BAD %0t hour tick missing", $time);
            final_report();
        end else begin
            cyc(1);
        end
    endtask : wait_tick

    task automatic check_terms(input logic [4:0] t, input logic src, input logic [15:0] extra);
        {gen_on, rev_on, fwd_on} = t;
        source_select = src;
        cyc(5);
        note(0, extra | {11'h000, t});
        note(2, extra | {11'h000, t});
    endtask : check_terms

    // code stays put past the pulse so the sampled edge sees it settled
    task automatic err_pulse(input logic [7:0] code);
        link_error_code = code;
        link_error = 1'b1;
        cyc(3);
        link_error = 1'b0;
        cyc(3);
    endtask : err_pulse

    initial begin
        cyc(12);
        reset = 1'b0;
        cyc(3);
        note(15, iosm_pkg::FW_VERSION);
        note(16, 16'h0000);
        note(13, 16'h0000);
        remote_keypad = 1'b1;
        keypad_version = 16'h2A5C;
        cyc(3);
        note(16, 16'h2A5C);
        note(19, 16'h0001);
        // link commands must stay hidden while the terminals are in control
        link_reset_cmd = 1'b1;
        link_forward_cmd = 1'b1;
        check_terms(5'h05, 1'b0, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            check_terms(5'($random(seed)), 1'(i), 16'h0000);
        end
        for (int v = 0; v < 4; v++) begin
            {relay_no_contact, transistor_output} = 2'(v);
            cyc(5);
            note(1, {7'h00, relay_no_contact, 7'h00, transistor_output});
            note(3, {7'h00, relay_no_contact, 7'h00, transistor_output});
        end
        link_control = 1'b1;
        link_reverse_cmd = 1'b1;
        link_reset_cmd = 1'b0;
        check_terms(5'h09, 1'b0, 16'h6000);
        note(1, 16'h0000);
        // wrap, saturation and the scale change at ten thousand
        fan_running = 1'b1;
        fan_onoff_control_setting = 1'b1;
        {nv_power_hours, nv_cap_hours, nv_fan_hours, nv_startups} = {16'hFFFF, 16'hFFFF,
            16'h270F, 16'h270F};
        cyc(4);
        wait_tick();
        nv_load = 1'b1;
        cyc(1);
        nv_load = 1'b0;
        wait_tick();
        cyc(2);
        note(4, 16'h0000);
        note(5, 16'hFFFF);
        note(9, 16'h1999);
        note(6, 16'h2710);
        note(10, 16'h03E8);
        note(12, 16'h0006);
        run_cmd = 1'b1;
        cyc(4);
        run_cmd = 1'b0;
        cyc(4);
        note(7, 16'h2710);
        note(11, 16'h03E8);
        fan_running = 1'b0;
        {nv_power_hours, nv_cap_hours, nv_fan_hours, nv_startups} = {16'h270F, 16'h0010,
            16'h1234, 16'h0003};
        cyc(4);
        wait_tick();
        nv_load = 1'b1;
        cyc(1);
        nv_load = 1'b0;
        wait_tick();
        cyc(2);
        note(4, 16'h2710);
        note(8, 16'h03E8);
        note(5, 16'h0011);
        note(6, 16'h1234);
        note(11, 16'h0003);
        fan_onoff_control_setting = 1'b0;
        wait_tick();
        cyc(2);
        note(6, 16'h1235);
        // a short peak well inside one hour window
        heat_sink_temp = 8'h10;
        output_current = 16'h0100;
        wait_tick();
        wait_tick();
        cyc(2);
        peak_heat = 8'($random(seed)) | 8'h80;
        peak_cur = 16'($random(seed)) | 16'h8000;
        heat_sink_temp = peak_heat;
        output_current = peak_cur;
        cyc(3);
        heat_sink_temp = 8'h10;
        output_current = 16'h0100;
        wait_tick();
        cyc(2);
        note(18, {8'h00, peak_heat});
        note(14, peak_cur);
        // error count runs through 9999 and returns to zero
        for (int i = 1; i <= 3; i++) begin
            code_now = 8'($random(seed));
            err_pulse(code_now);
            note(13, 16'(i));
            note(17, {8'h00, code_now});
        end
        for (int i = 4; i <= 10000; i++) begin
            err_pulse(8'h5A);
        end
        note(13, 16'h0000);
        note(17, 16'h005A);
        cyc(2);
        final_report();
    end
endmodule : io_status_and_maintenance_counters_test
`default_nettype wire
